// file: pdmc_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PDMC_DEFINES_SVH
`define PDMC_DEFINES_SVH
`define PDMC_OFF_CTRL_ONE   12'h000
`define PDMC_OFF_CTRL_TWO   12'h004
`define PDMC_OFF_STATUS     12'h008
`define PDMC_RST_CTRL_ONE   8'h07
`define PDMC_RST_CTRL_TWO   8'he0
`define PDMC_B_STANDBY      7
`define PDMC_B_STS_HI       6
`define PDMC_B_STS_LO       4
`define PDMC_B_LOW_SPEED_ON_BIT         3
`define PDMC_B_NESEL        4
`define PDMC_B_DTON         3
`define PDMC_B_MEDIUM_SPEED_SELECT         2
`define PDMC_B_SA_HI        1
`define PDMC_B_SA_LO        0
`define PDMC_SETTLE_MIN     8192
`define PDMC_CNT_W          18
`define PDMC_SRC_W          22
// Wake source bits: timers A,B,C,F,G; ext 0..4; pins 0..7; serial 1..3; A/D.
`define PDMC_SRC_TMR_A      22'h000001
`define PDMC_SRC_TIMERS     22'h00001f
`define PDMC_SRC_EXT0       22'h000020
`define PDMC_SRC_EXT1       22'h000040
`define PDMC_SRC_EXT_ALL    22'h0003e0
`define PDMC_SRC_PINS       22'h03fc00
`define PDMC_SRC_SER_AD     22'h3c0000
`endif

// file: pdmc_pkg.sv
// Types shared by the power-down mode controller.
package pdmc_pkg;
  typedef enum logic [2:0] {
    PDMC_ACT_HI  = 3'b000,
    PDMC_ACT_MED = 3'b001,
    PDMC_SUB_ACT = 3'b010,
    PDMC_SLEEP   = 3'b011,
    PDMC_STANDBY = 3'b100,
    PDMC_WATCH   = 3'b101,
    PDMC_SETTLE  = 3'b110
  } pdmc_mode_t;

  typedef struct packed {
    logic       ctrl_hiz;
    logic       ctrl_hold;
    logic       cpu_halt;
    logic       osc_en;
    logic       periph_halt;
    logic       pwm_halt;
    logic       med_speed;
    logic [1:0] sub_clk;
  } pdmc_ctrl_t;

  typedef struct packed {
    pdmc_mode_t  mode;
    logic [17:0] cnt;
    logic        settle_to_med;
    logic        software_standby_bit;
    logic [2:0]  settle_timer_sel;
    logic        low_speed_on_bit;
    logic        noise_sel;
    logic        direct_xfer;
    logic        medium_speed_select;
    logic        sub_clock_div_hi;
    logic        sub_clock_div_lo;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wake_start;
    pdmc_ctrl_t  ctl;
  } pdmc_state_t;
endpackage : pdmc_pkg

// file: pdmc_top.sv
// Power-down mode controller with APB register access.
`timescale 1ns/1ps
`include "pdmc_defines.svh"

// Summary of operation
// - Leaving sleep, standby or watch with low-speed bit clear resumes medium speed if select bit set.
// - Subactive divider field: 00 gives /8, 01 gives /4, 1x gives /2.
// - Writes to the subactive divider field are ignored in subactive mode.
// - Sleep command in active mode with standby and low-speed bits clear sleeps.
// - Sleep halts the CPU; peripherals except PWM keep running.
// - Sleep ends on timer, external, pin, serial or A/D interrupts.
// - No wakeup while the CPU mask bit is set or the source disabled.
// - Reset pin low in sleep ends sleep and resets the CPU.
// - Sleep command in active mode, standby set, low-speed and timer bit clear.
// - Standby stops the clock generator; CPU and peripherals halt.
// - Entering standby puts port pins into high impedance.
// - Standby ends only on external 0, external 1, wakeup pins or reset.
// - Standby wakeup restarts oscillator and waits the selected settle count.
// - Reset pin in standby restarts the oscillator and ends standby.
// - Sleep command with standby and timer mode bits set enters watch.
// - Watch halts peripherals except timer A and LCD; pins hold state.
// - Watch ends only on timer A, external 0, wakeup pins or reset.
// - Watch wakeup goes to high speed, medium speed or subactive by bits.
// - Watch wakeup to active mode waits the settle count first.
// - Settle field: 8192, 16384, 32768, 65536, or 131072 for 1xx.
// - Low-speed bit, reset 0, selects subclock after watch ends.
module pdmc_top
  import pdmc_pkg::*;
#(
  parameter int P_SETTLE_MIN = `PDMC_SETTLE_MIN
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_sleep_exec,
  input  wire logic        i_cpu_int_mask,
  input  wire logic        i_timer_a_mode_bit,
  input  wire logic [21:0] i_wake_req,
  input  wire logic [21:0] i_wake_en,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [2:0]  o_mode,
  output logic             o_cpu_halt,
  output logic             o_osc_en,
  output logic             o_periph_halt,
  output logic             o_pwm_halt,
  output logic             o_port_hiz,
  output logic             o_port_hold,
  output logic             o_medium_speed,
  output logic      [1:0]  o_sub_clk_sel,
  output logic             o_noise_sel,
  output logic             o_direct_xfer,
  output logic             o_wake_start
);

  pdmc_state_t st_r;
  pdmc_state_t st_nxt;

  logic        apb_wr;
  logic        apb_rd_req;
  logic        active;
  logic [21:0] hit;
  logic [7:0]  ctrl_one_rd;
  logic [7:0]  ctrl_two_rd;

  // Settle length in cycles of the system clock, as a down-count target.
  function automatic logic [17:0] settle_cycles(input logic [2:0] sel);
    logic [17:0] base;
    base = 18'(P_SETTLE_MIN);
    if (sel[2]) begin
      settle_cycles = base << 4;
    end else begin
      settle_cycles = base << sel[1:0];
    end
  endfunction : settle_cycles

  // True when an enabled, unmasked request hits the given source set.
  function automatic logic wake_from(input logic [21:0] set,
                                     input logic [21:0] h);
    wake_from = |(set & h);
  endfunction : wake_from

  assign hit    = i_cpu_int_mask ? 22'h000000
                                 : (i_wake_req & i_wake_en);
  assign active = (st_r.mode == PDMC_ACT_HI) ||
                  (st_r.mode == PDMC_ACT_MED);
  assign apb_wr = i_psel && i_penable && st_r.pready && i_pwrite;
  assign apb_rd_req = i_psel && i_penable && !st_r.pready;

  assign ctrl_one_rd = {st_r.software_standby_bit, st_r.settle_timer_sel,
                        st_r.low_speed_on_bit, 3'h7};
  assign ctrl_two_rd = {3'h7, st_r.noise_sel, st_r.direct_xfer,
                        st_r.medium_speed_select, st_r.sub_clock_div_hi,
                        st_r.sub_clock_div_lo};

  always_comb begin
    st_nxt            = st_r;
    st_nxt.wake_start = 1'b0;
    st_nxt.pready     = 1'b0;
    st_nxt.pslverr    = 1'b0;

    // APB answers in the second access cycle.
    if (apb_rd_req) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h00000000;
      unique case (i_paddr)
        `PDMC_OFF_CTRL_ONE: st_nxt.prdata = {24'h000000, ctrl_one_rd};
        `PDMC_OFF_CTRL_TWO: st_nxt.prdata = {24'h000000, ctrl_two_rd};
        `PDMC_OFF_STATUS:   st_nxt.prdata = {29'h00000000, st_r.mode};
        default:            st_nxt.pslverr = 1'b1;
      endcase
    end

    if (apb_wr && i_paddr == `PDMC_OFF_CTRL_ONE) begin
      st_nxt.software_standby_bit = i_pwdata[`PDMC_B_STANDBY];
      st_nxt.settle_timer_sel = i_pwdata[`PDMC_B_STS_HI:`PDMC_B_STS_LO];
      st_nxt.low_speed_on_bit = i_pwdata[`PDMC_B_LOW_SPEED_ON_BIT];
    end
    if (apb_wr && i_paddr == `PDMC_OFF_CTRL_TWO) begin
      st_nxt.noise_sel           = i_pwdata[`PDMC_B_NESEL];
      st_nxt.direct_xfer         = i_pwdata[`PDMC_B_DTON];
      st_nxt.medium_speed_select = i_pwdata[`PDMC_B_MEDIUM_SPEED_SELECT];
      if (st_r.mode != PDMC_SUB_ACT) begin
        st_nxt.sub_clock_div_hi = i_pwdata[`PDMC_B_SA_HI];
        st_nxt.sub_clock_div_lo = i_pwdata[`PDMC_B_SA_LO];
      end
    end

    unique case (st_r.mode)
      PDMC_ACT_HI, PDMC_ACT_MED: begin
        if (i_sleep_exec) begin
          if (!st_r.software_standby_bit && !st_r.low_speed_on_bit) begin
            st_nxt.mode = PDMC_SLEEP;
          end else if (st_r.software_standby_bit && i_timer_a_mode_bit) begin
            st_nxt.mode = PDMC_WATCH;
          end else if (st_r.software_standby_bit &&
                       !st_r.low_speed_on_bit) begin
            st_nxt.mode = PDMC_STANDBY;
          end
        end
      end
      PDMC_SUB_ACT: begin
        if (i_sleep_exec && st_r.software_standby_bit &&
            i_timer_a_mode_bit) begin
          st_nxt.mode = PDMC_WATCH;
        end
      end
      PDMC_SLEEP: begin
        if (wake_from(`PDMC_SRC_TIMERS | `PDMC_SRC_EXT_ALL |
                      `PDMC_SRC_PINS | `PDMC_SRC_SER_AD, hit)) begin
          st_nxt.mode = st_r.medium_speed_select ? PDMC_ACT_MED
                                                 : PDMC_ACT_HI;
          st_nxt.wake_start = 1'b1;
        end
      end
      PDMC_STANDBY: begin
        if (wake_from(`PDMC_SRC_EXT0 | `PDMC_SRC_EXT1 |
                      `PDMC_SRC_PINS, hit)) begin
          st_nxt.mode = PDMC_SETTLE;
          st_nxt.cnt  = settle_cycles(st_r.settle_timer_sel) - 18'h1;
          st_nxt.settle_to_med = st_r.medium_speed_select;
        end
      end
      PDMC_WATCH: begin
        if (wake_from(`PDMC_SRC_TMR_A | `PDMC_SRC_EXT0 |
                      `PDMC_SRC_PINS, hit)) begin
          if (st_r.low_speed_on_bit) begin
            st_nxt.mode = PDMC_SUB_ACT;
            st_nxt.wake_start = 1'b1;
          end else begin
            st_nxt.mode = PDMC_SETTLE;
            st_nxt.cnt  = settle_cycles(st_r.settle_timer_sel) - 18'h1;
            st_nxt.settle_to_med = st_r.medium_speed_select;
          end
        end
      end
      PDMC_SETTLE: begin
        if (st_r.cnt == 18'h0) begin
          st_nxt.mode = st_r.settle_to_med ? PDMC_ACT_MED
                                           : PDMC_ACT_HI;
          st_nxt.wake_start = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 18'h1;
        end
      end
      default: st_nxt.mode = PDMC_ACT_HI;
    endcase

    // Clock and pin controls follow the mode being entered.
    st_nxt.ctl.cpu_halt    = (st_nxt.mode == PDMC_SLEEP) ||
                             (st_nxt.mode == PDMC_STANDBY) ||
                             (st_nxt.mode == PDMC_WATCH) ||
                             (st_nxt.mode == PDMC_SETTLE);
    st_nxt.ctl.pwm_halt    = st_nxt.ctl.cpu_halt;
    st_nxt.ctl.osc_en      = (st_nxt.mode != PDMC_STANDBY) &&
                             (st_nxt.mode != PDMC_WATCH);
    st_nxt.ctl.periph_halt = (st_nxt.mode == PDMC_STANDBY) ||
                             (st_nxt.mode == PDMC_WATCH) ||
                             (st_nxt.mode == PDMC_SETTLE);
    st_nxt.ctl.ctrl_hiz    = (st_nxt.mode == PDMC_STANDBY) ||
                             (st_nxt.mode == PDMC_SETTLE &&
                              st_r.mode != PDMC_WATCH &&
                              st_r.ctl.ctrl_hiz);
    st_nxt.ctl.ctrl_hold   = (st_nxt.mode == PDMC_WATCH) ||
                             (st_nxt.mode == PDMC_SETTLE &&
                              !st_nxt.ctl.ctrl_hiz);
    // Speed and divider outputs are decoded here so that they leave a flop.
    st_nxt.ctl.med_speed   = (st_nxt.mode == PDMC_ACT_MED);
    st_nxt.ctl.sub_clk     = st_nxt.sub_clock_div_hi ? 2'h2
                             : {1'b0, st_nxt.sub_clock_div_lo};
  end

  // Reset pin restarts the oscillator and returns to high speed.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r                      <= '0;
      st_r.mode                 <= PDMC_ACT_HI;
      st_r.ctl.osc_en           <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata       = st_r.prdata;
  assign o_pready       = st_r.pready;
  assign o_pslverr      = st_r.pslverr;
  assign o_mode         = st_r.mode;
  assign o_cpu_halt     = st_r.ctl.cpu_halt;
  assign o_osc_en       = st_r.ctl.osc_en;
  assign o_periph_halt  = st_r.ctl.periph_halt;
  assign o_pwm_halt     = st_r.ctl.pwm_halt;
  assign o_port_hiz     = st_r.ctl.ctrl_hiz;
  assign o_port_hold    = st_r.ctl.ctrl_hold;
  assign o_medium_speed = st_r.ctl.med_speed;
  assign o_sub_clk_sel  = st_r.ctl.sub_clk;
  assign o_noise_sel    = st_r.noise_sel;
  assign o_direct_xfer  = st_r.direct_xfer;
  assign o_wake_start   = st_r.wake_start;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  sleep_entry_a: assert property (
    (active && i_sleep_exec && !st_r.software_standby_bit &&
     !st_r.low_speed_on_bit) |=> (st_r.mode == PDMC_SLEEP && o_cpu_halt))
    else $error("Sleep not entered from active mode.");

  standby_entry_a: assert property (
    (active && i_sleep_exec && st_r.software_standby_bit &&
     !st_r.low_speed_on_bit && !i_timer_a_mode_bit)
    |=> (st_r.mode == PDMC_STANDBY && !o_osc_en && o_port_hiz))
    else $error("Standby not entered or clock not stopped.");

  watch_entry_a: assert property (
    ((active || st_r.mode == PDMC_SUB_ACT) && i_sleep_exec &&
     st_r.software_standby_bit && i_timer_a_mode_bit)
    |=> (st_r.mode == PDMC_WATCH && o_port_hold))
    else $error("Watch mode not entered.");

  sleep_resume_a: assert property (
    (st_r.mode == PDMC_SLEEP && |hit)
    |=> (o_wake_start && o_medium_speed == $past(st_r.medium_speed_select)))
    else $error("Sleep exit went to the wrong speed.");

  masked_hold_a: assert property (
    (i_cpu_int_mask && (st_r.mode == PDMC_SLEEP ||
     st_r.mode == PDMC_STANDBY || st_r.mode == PDMC_WATCH))
    |=> $stable(st_r.mode))
    else $error("Masked request ended a power-down mode.");

  standby_src_a: assert property (
    (st_r.mode == PDMC_STANDBY &&
     !wake_from(`PDMC_SRC_EXT0 | `PDMC_SRC_EXT1 | `PDMC_SRC_PINS, hit))
    |=> st_r.mode == PDMC_STANDBY)
    else $error("Standby left on an ineligible source.");

  settle_end_a: assert property (
    (st_r.mode == PDMC_SETTLE && st_r.cnt == 18'h0)
    |=> (active && o_wake_start && !o_cpu_halt))
    else $error("Settle wait did not end in active mode.");

  settle_len_a: assert property (
    (st_r.mode == PDMC_STANDBY && st_nxt.mode == PDMC_SETTLE)
    |=> st_r.cnt == settle_cycles($past(st_r.settle_timer_sel)) - 18'h1)
    else $error("Settle count does not match the timer field.");

  watch_sub_a: assert property (
    (st_r.mode == PDMC_WATCH && st_r.low_speed_on_bit &&
     wake_from(`PDMC_SRC_TMR_A | `PDMC_SRC_EXT0 | `PDMC_SRC_PINS, hit))
    |=> st_r.mode == PDMC_SUB_ACT)
    else $error("Watch wakeup with low speed bit missed subactive.");

  sa_lock_a: assert property (
    (st_r.mode == PDMC_SUB_ACT) |=> $stable(o_sub_clk_sel))
    else $error("Subactive divider changed in subactive mode.");

  sleep_periph_a: assert property (
    (st_r.mode == PDMC_SLEEP)
    |-> (o_cpu_halt && o_pwm_halt && !o_periph_halt))
    else $error("Sleep mode halted the wrong units.");

  standby_pins_a: assert property (
    (st_r.mode == PDMC_STANDBY)
    |-> (o_port_hiz && !o_port_hold && !o_osc_en && o_periph_halt))
    else $error("Standby pins or clock in the wrong state.");

  watch_pins_a: assert property (
    (st_r.mode == PDMC_WATCH)
    |-> (o_port_hold && !o_port_hiz && o_periph_halt && o_cpu_halt))
    else $error("Watch mode pins or halts in the wrong state.");

  settle_hold_a: assert property (
    (st_r.mode == PDMC_SETTLE && st_r.cnt != 18'h0)
    |=> (st_r.mode == PDMC_SETTLE && o_cpu_halt && o_osc_en &&
         !o_wake_start))
    else $error("Settle wait ended early or released the CPU.");

  watch_active_a: assert property (
    (st_r.mode == PDMC_WATCH && !st_r.low_speed_on_bit &&
     wake_from(`PDMC_SRC_TMR_A | `PDMC_SRC_EXT0 | `PDMC_SRC_PINS, hit))
    |=> (st_r.mode == PDMC_SETTLE && o_osc_en && o_port_hold &&
         !o_wake_start))
    else $error("Watch wakeup to active skipped the settle wait.");

  standby_cov_c: cover property (
    st_r.mode == PDMC_STANDBY ##1 st_r.mode == PDMC_SETTLE);
  watch_cov_c: cover property (
    st_r.mode == PDMC_WATCH ##1 st_r.mode == PDMC_SUB_ACT);
  sleep_cov_c: cover property (
    st_r.mode == PDMC_SLEEP ##1 st_r.mode == PDMC_ACT_MED);
  unmapped_cov_c: cover property (o_pready && o_pslverr);
  settle_cov_c: cover property (
    st_r.mode == PDMC_WATCH ##1 st_r.mode == PDMC_SETTLE);

endmodule : pdmc_top

// file: pdmc_cpu_model.sv
// Behavioural CPU core and interrupt controller facing the mode controller.
`timescale 1ns/1ps
module pdmc_cpu_model
  import pdmc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [2:0]  i_mode,
  output logic             o_sleep_exec,
  output logic             o_int_mask,
  output logic             o_tmr_bit,
  output logic      [21:0] o_req,
  output logic      [21:0] o_en
);
  initial begin
    o_sleep_exec = 1'b0;
    o_int_mask   = 1'b0;
    o_tmr_bit    = 1'b0;
    o_req        = 22'h000000;
    o_en         = 22'h3fffff;
  end
  // Level requests stay up until a running mode takes them.
  always @(posedge i_clk) begin
    if (i_mode <= 3'h2) begin
      o_req <= 22'h000000;
    end
  end
  task automatic sleep_cmd();
    @(posedge i_clk);
    o_sleep_exec <= 1'b1;
    @(posedge i_clk);
    o_sleep_exec <= 1'b0;
  endtask : sleep_cmd
  task automatic raise(input logic [21:0] src);
    @(posedge i_clk);
    o_req <= o_req | src;
  endtask : raise
  task automatic set_ctl(input logic m, input logic t, input logic [21:0] e);
    @(posedge i_clk);
    o_int_mask <= m;
    o_tmr_bit  <= t;
    o_en       <= e;
  endtask : set_ctl
endmodule : pdmc_cpu_model

// file: test_power_down_mode_controller.sv
// Self-checking testbench for the power-down mode controller.
`timescale 1ns/1ps
`include "pdmc_defines.svh"
module test_power_down_mode_controller
  import pdmc_pkg::*;
();
  localparam int P = 4;
  logic        clk, rst_n, psel, pen, pwr, pready, pslverr, err, sx, mask;
  logic        tmr, halt, osc, phalt, pwm, hiz, hold, med, wst, ns, dt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  mode;
  logic [1:0]  subsel;
  logic [21:0] req, en;
  int          errors, n_tests, n;
  pdmc_top #(.P_SETTLE_MIN(P)) dut_u (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_sleep_exec(sx), .i_cpu_int_mask(mask),
    .i_timer_a_mode_bit(tmr), .i_wake_req(req), .i_wake_en(en),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_mode(mode), .o_cpu_halt(halt), .o_osc_en(osc),
    .o_periph_halt(phalt), .o_pwm_halt(pwm), .o_port_hiz(hiz),
    .o_port_hold(hold), .o_medium_speed(med), .o_sub_clk_sel(subsel),
    .o_noise_sel(ns), .o_direct_xfer(dt), .o_wake_start(wst));
  pdmc_cpu_model cpu_u (.i_clk(clk), .i_mode(mode), .o_sleep_exec(sx),
    .o_int_mask(mask), .o_tmr_bit(tmr), .o_req(req), .o_en(en));
  task automatic conclude();
    $display("Counts: %0d checks, %0d errors", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("pready wait", 32'h1, 32'h0);
      conclude();
    end
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register read", e, rd);
  endtask : rdchk
  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) begin
      chk("mode wait", 32'(m), 32'(mode));
      conclude();
    end
  endtask : wait_mode
  task automatic settle(input int cnt);
    wait_mode(PDMC_SETTLE);
    n = 0;
    while (mode === PDMC_SETTLE && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("settle cycles", 32'(cnt), 32'(n));
  endtask : settle
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    chk("watchdog", 32'h0, 32'h1);
    conclude();
  end
  initial begin
    {rst_n, psel, pen, pwr, paddr, pwdata, errors, n_tests} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`PDMC_OFF_CTRL_ONE, 32'h07);
    rdchk(`PDMC_OFF_CTRL_TWO, 32'he0);
    rdchk(`PDMC_OFF_STATUS, 32'h0);
    rdchk(12'h00c, 32'h0);
    chk("slave error", 32'h1, 32'(err));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'(i));
      rdchk(`PDMC_OFF_CTRL_TWO, 32'he0 | 32'(i));
      chk("sub clock", (i > 1) ? 32'h2 : 32'(i), 32'(subsel));
    end
    apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'h18);
    rdchk(`PDMC_OFF_CTRL_TWO, 32'hf8);
    chk("noise select", 32'h1, 32'(ns));
    chk("direct transfer", 32'h1, 32'(dt));
    $display("test registers done");
    apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'h0);
    apb(1'b1, `PDMC_OFF_CTRL_ONE, 32'h0);
    cpu_u.set_ctl(1'b1, 1'b0, 22'h3fffff);
    cpu_u.sleep_cmd();
    wait_mode(PDMC_SLEEP);
    chk("cpu halt", 32'h1, 32'(halt));
    chk("pwm halt", 32'h1, 32'(pwm));
    chk("periph halt", 32'h0, 32'(phalt));
    cpu_u.raise(`PDMC_SRC_SER_AD);
    repeat (5) @(posedge clk);
    chk("masked wake", 32'(PDMC_SLEEP), 32'(mode));
    cpu_u.set_ctl(1'b0, 1'b0, ~`PDMC_SRC_SER_AD);
    repeat (5) @(posedge clk);
    chk("disabled wake", 32'(PDMC_SLEEP), 32'(mode));
    cpu_u.set_ctl(1'b0, 1'b0, 22'h3fffff);
    wait_mode(PDMC_ACT_HI);
    chk("wake start", 32'h1, 32'(wst));
    apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'h04);
    cpu_u.sleep_cmd();
    wait_mode(PDMC_SLEEP);
    cpu_u.raise(22'h000004);
    wait_mode(PDMC_ACT_MED);
    chk("medium speed", 32'h1, 32'(med));
    $display("test sleep done");
    apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'h0);
    // Scaled counts stand in for a crystal settling time.
    for (int s = 0; s < 5; s++) begin
      apb(1'b1, `PDMC_OFF_CTRL_ONE, 32'h80 | (32'(s) << 4));
      cpu_u.sleep_cmd();
      wait_mode(PDMC_STANDBY);
      chk("osc on", 32'h0, 32'(osc));
      chk("periph halt", 32'h1, 32'(phalt));
      chk("port hiz", 32'h1, 32'(hiz));
      cpu_u.raise(`PDMC_SRC_TMR_A);
      repeat (4) @(posedge clk);
      chk("foreign wake", 32'(PDMC_STANDBY), 32'(mode));
      cpu_u.raise(s[0] ? `PDMC_SRC_EXT1 : `PDMC_SRC_EXT0);
      settle((s > 3) ? P * 16 : P << s);
      wait_mode(PDMC_ACT_HI);
      chk("wake start", 32'h1, 32'(wst));
    end
    $display("test standby done");
    apb(1'b1, `PDMC_OFF_CTRL_ONE, 32'h88);
    cpu_u.set_ctl(1'b0, 1'b1, 22'h3fffff);
    cpu_u.sleep_cmd();
    wait_mode(PDMC_WATCH);
    chk("port hold", 32'h1, 32'(hold));
    chk("osc on", 32'h0, 32'(osc));
    cpu_u.raise(`PDMC_SRC_SER_AD);
    repeat (4) @(posedge clk);
    chk("foreign wake", 32'(PDMC_WATCH), 32'(mode));
    cpu_u.raise(`PDMC_SRC_TMR_A);
    wait_mode(PDMC_SUB_ACT);
    apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'h02);
    rdchk(`PDMC_OFF_CTRL_TWO, 32'he0);
    chk("sub clock", 32'h0, 32'(subsel));
    apb(1'b1, `PDMC_OFF_CTRL_ONE, 32'h90);
    apb(1'b1, `PDMC_OFF_CTRL_TWO, 32'h04);
    cpu_u.sleep_cmd();
    wait_mode(PDMC_WATCH);
    cpu_u.raise(`PDMC_SRC_PINS);
    settle(P * 2);
    wait_mode(PDMC_ACT_MED);
    $display("test watch done");
    apb(1'b1, `PDMC_OFF_CTRL_ONE, 32'h0);
    cpu_u.set_ctl(1'b0, 1'b0, 22'h3fffff);
    cpu_u.sleep_cmd();
    wait_mode(PDMC_SLEEP);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset mode", 32'(PDMC_ACT_HI), 32'(mode));
    chk("reset halt", 32'h0, 32'(halt));
    chk("reset osc", 32'h1, 32'(osc));
    @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`PDMC_OFF_CTRL_ONE, 32'h07);
    rdchk(`PDMC_OFF_CTRL_TWO, 32'he0);
    apb(1'b1, `PDMC_OFF_CTRL_ONE, 32'h80);
    cpu_u.sleep_cmd();
    wait_mode(PDMC_STANDBY);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("standby reset osc", 32'h1, 32'(osc));
    chk("standby reset mode", 32'(PDMC_ACT_HI), 32'(mode));
    chk("standby reset hiz", 32'h0, 32'(hiz));
    @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`PDMC_OFF_CTRL_ONE, 32'h07);
    $display("test reset done");
    conclude();
  end
endmodule : test_power_down_mode_controller
